// >>> hw/usp_pkg.sv
`default_nettype none
package usp_pkg;

  // ********************************
  // Clocking and baud timing
  // ********************************
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned REF_MHZ = 48;
  localparam int unsigned REF_HZ = REF_MHZ * 1000000;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned PRESCALE = 8;
  localparam int unsigned RATE_TABLE [8] = '{115200, 57600, 38400, 28800, 19200, 14400, 9600, 7200};
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] PRE_LAST = 3'(PRESCALE - 1);

  // Reference ticks per sixteenth of a bit, rounded to nearest
  function automatic logic [8:0] usp_ref_div(input logic [2:0] sel);
    int unsigned rate;
    rate = RATE_TABLE[sel];
    return 9'((REF_HZ + rate * OVERSAMPLE / 2) / (rate * OVERSAMPLE));
  endfunction

  // ********************************
  // Register map (word indices)
  // ********************************
  localparam logic [15:0] IDX_CONTROL = 16'hc0e0;
  localparam logic [15:0] IDX_STATUS = 16'hc0e2;
  localparam logic [15:0] IDX_DATA = 16'hc0e4;
  localparam logic [15:0] IDX_IRQ_STAT = 16'hc100;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hc102;

  function automatic logic [31:0] usp_byte_addr(input logic [15:0] idx);
    return {14'h0000, idx, 2'b00};
  endfunction

  // ********************************
  // Field layout and reset values
  // ********************************
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_BAUD_LSB = 1;
  localparam int CTL_SCALE_BIT = 4;
  localparam logic [15:0] CTL_WR_MASK = 16'h001f;
  localparam logic [15:0] CTL_RESET = 16'h0007;
  localparam int STS_TXF_BIT = 0;
  localparam int STS_RXF_BIT = 1;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam int IRQ_OVR = 2;
  localparam int IRQ_FRM = 3;
  localparam int IRQ_W = 4;

  // ********************************
  // Types
  // ********************************
  typedef struct packed {
    logic out;
    logic oe;
  } usp_pad_t;

  typedef struct packed {
    logic [2:0] baud_sel;
    logic baud_divide_by_eight;
    logic run;
  } usp_rate_cfg_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } usp_tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } usp_rx_state_t;

endpackage
`default_nettype wire

// >>> hw/usp_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module usp_tick_gen (
  input wire logic clk,
  input wire logic rst,
  input wire usp_pkg::usp_rate_cfg_t cfg,
  output logic tick
);
  import usp_pkg::*;

  localparam logic [6:0] REF_STEP = 7'(REF_MHZ);
  localparam logic [6:0] CLK_STEP = 7'(CLK_MHZ);

  typedef struct packed {
    logic [6:0] acc;
    logic [8:0] cnt;
    logic [2:0] pre;
    logic tick;
  } usp_tg_state_t;

  usp_tg_state_t s_r;
  usp_tg_state_t s_nxt;
  logic [6:0] acc_sum;
  logic [8:0] div_last;

  // ********************************
  // Reference tick and baud divider
  // ********************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    acc_sum = 7'(s_r.acc + REF_STEP);
    div_last = 9'(usp_ref_div(cfg.baud_sel) - 9'h001);
    if (!cfg.run) begin
      s_nxt = '0;
    end else if (acc_sum >= CLK_STEP) begin
      // 48 of every 50 clocks carry a reference tick
      s_nxt.acc = 7'(acc_sum - CLK_STEP);
      // Compare with >= so a baud change mid-count cannot overrun
      if (s_r.cnt >= div_last) begin
        s_nxt.cnt = '0;
        s_nxt.pre = 3'(s_r.pre + 3'h1);
        if (!cfg.baud_divide_by_eight || s_r.pre == PRE_LAST) begin
          s_nxt.tick = 1'b1;
        end
      end else begin
        s_nxt.cnt = 9'(s_r.cnt + 9'h001);
      end
    end else begin
      s_nxt.acc = acc_sum;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule
`default_nettype wire

// >>> hw/usp_serial_port.sv
// Summary of operation
// - Enable bit runs port, else pins go GPIO
// - Baud timing derived from 48 MHz reference
// - Scale bit divides selected rate by eight
// - Baud field picks one of eight rates
// - Receive full set on byte, read clears
// - Receive full raises processor interrupt five
// - Data write sets transmit full at once
// - Transmit full clears after stop bit
// - Empty transmit buffer raises interrupt four
// - Data write sends byte, read returns received
// - Status register read only, writes ignored
`timescale 1ns/1ps
`default_nettype none
module usp_serial_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_pin,
  input wire usp_pkg::usp_pad_t gio_drv_twenty_eight,
  input wire usp_pkg::usp_pad_t gio_drv_twenty_seven,
  output usp_pkg::usp_pad_t general_io_pin_twenty_eight,
  output usp_pkg::usp_pad_t general_io_pin_twenty_seven,
  input wire logic uart_int_enable,
  output logic cpu_irq_four,
  output logic cpu_irq_five,
  output logic irq
);
  import usp_pkg::*;

  typedef struct packed {
    logic [15:0] ctl;
    logic txf;
    logic rxf;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imsk;
    logic wr_pend;
    logic rd_wait;
    logic [15:0] a_idx;
    logic [31:0] rdata;
    usp_tx_state_t tx_st;
    logic [3:0] tx_tick;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_line;
    usp_rx_state_t rx_st;
    logic [3:0] rx_tick;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_meta;
    logic rx_sync;
    usp_pad_t pad28;
    usp_pad_t pad27;
    logic irq4;
    logic irq5;
    logic irq;
  } usp_state_t;

  usp_state_t s_r;
  usp_state_t s_nxt;
  usp_rate_cfg_t rate_cfg;
  logic tick;
  logic run;
  logic accept;
  logic [15:0] wr_val;
  logic rd_clear;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] w1c;

  // ********************************
  // Baud tick generator
  // ********************************
  assign run = s_r.ctl[CTL_EN_BIT];
  assign rate_cfg.baud_sel = s_r.ctl[CTL_BAUD_LSB +: 3];
  assign rate_cfg.baud_divide_by_eight = s_r.ctl[CTL_SCALE_BIT];
  assign rate_cfg.run = run;

  usp_tick_gen u_tick (
    .clk(clk),
    .rst(rst),
    .cfg(rate_cfg),
    .tick(tick)
  );

  // ********************************
  // Bus slave
  // ********************************
  assign accept = hsel && htrans[1] && hready;
  assign wr_val = hwdata[15:0];
  // A read costs one wait state so it always sees a preceding write
  assign hreadyout = !s_r.rd_wait;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;

  function automatic logic usp_mapped(input logic [31:0] addr);
    logic hit;
    if (addr == usp_byte_addr(IDX_CONTROL)) begin
      hit = 1'b1;
    end else if (addr == usp_byte_addr(IDX_STATUS)) begin
      hit = 1'b1;
    end else if (addr == usp_byte_addr(IDX_DATA)) begin
      hit = 1'b1;
    end else if (addr == usp_byte_addr(IDX_IRQ_STAT)) begin
      hit = 1'b1;
    end else if (addr == usp_byte_addr(IDX_IRQ_MASK)) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    s_nxt = s_r;
    ev = '0;
    w1c = '0;
    rd_clear = 1'b0;

    // Synchroniser for the receive pin
    s_nxt.rx_meta = rx_pin;
    s_nxt.rx_sync = s_r.rx_meta;

    // Address phase capture; unmapped addresses decode to an index nothing matches
    s_nxt.wr_pend = 1'b0;
    if (accept) begin
      s_nxt.a_idx = usp_mapped(haddr) ? haddr[17:2] : 16'h0000;
      s_nxt.wr_pend = hwrite;
      s_nxt.rd_wait = !hwrite;
    end

    // Write data phase
    if (s_r.wr_pend) begin
      if (s_r.a_idx == IDX_CONTROL) begin
        s_nxt.ctl = wr_val & CTL_WR_MASK;
      end else if (s_r.a_idx == IDX_STATUS) begin
        s_nxt.ctl = s_r.ctl;
      end else if (s_r.a_idx == IDX_DATA) begin
        // A write while full or disabled is dropped
        if (run && !s_r.txf) begin
          s_nxt.tx_buf = wr_val[7:0];
          s_nxt.txf = 1'b1;
        end
      end else if (s_r.a_idx == IDX_IRQ_STAT) begin
        w1c = wr_val[IRQ_W-1:0];
      end else if (s_r.a_idx == IDX_IRQ_MASK) begin
        s_nxt.imsk = wr_val[IRQ_W-1:0];
      end
    end

    // ********************************
    // Read data
    // ********************************
    // Read wait cycle: sample register, apply read side effect
    if (s_r.rd_wait) begin
      s_nxt.rd_wait = 1'b0;
      s_nxt.rdata = '0;
      if (s_r.a_idx == IDX_CONTROL) begin
        s_nxt.rdata[15:0] = s_r.ctl;
      end else if (s_r.a_idx == IDX_STATUS) begin
        s_nxt.rdata[STS_RXF_BIT] = s_r.rxf;
        s_nxt.rdata[STS_TXF_BIT] = s_r.txf;
      end else if (s_r.a_idx == IDX_DATA) begin
        s_nxt.rdata[7:0] = s_r.rx_buf;
        rd_clear = 1'b1;
        s_nxt.rxf = 1'b0;
      end else if (s_r.a_idx == IDX_IRQ_STAT) begin
        s_nxt.rdata[IRQ_W-1:0] = s_r.ist;
      end else if (s_r.a_idx == IDX_IRQ_MASK) begin
        s_nxt.rdata[IRQ_W-1:0] = s_r.imsk;
      end
    end

    // ********************************
    // Transmitter
    // ********************************
    if (!run) begin
      // Disabling aborts a frame in flight and empties the buffer
      s_nxt.tx_st = TX_IDLE;
      s_nxt.tx_line = 1'b1;
      s_nxt.txf = 1'b0;
    end else if (tick) begin
      case (s_r.tx_st)
        TX_IDLE: begin
          if (s_r.txf) begin
            s_nxt.tx_st = TX_START;
            s_nxt.tx_sh = s_r.tx_buf;
            s_nxt.tx_tick = '0;
            s_nxt.tx_bit = '0;
            s_nxt.tx_line = 1'b0;
          end
        end
        TX_START: begin
          s_nxt.tx_tick = 4'(s_r.tx_tick + 4'h1);
          if (s_r.tx_tick == TICK_LAST) begin
            s_nxt.tx_st = TX_DATA;
            s_nxt.tx_line = s_r.tx_sh[0];
          end
        end
        TX_DATA: begin
          s_nxt.tx_tick = 4'(s_r.tx_tick + 4'h1);
          if (s_r.tx_tick == TICK_LAST) begin
            if (s_r.tx_bit == BIT_LAST) begin
              s_nxt.tx_st = TX_STOP;
              s_nxt.tx_line = 1'b1;
            end else begin
              s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
              s_nxt.tx_line = s_r.tx_sh[1];
              s_nxt.tx_bit = 3'(s_r.tx_bit + 3'h1);
            end
          end
        end
        TX_STOP: begin
          s_nxt.tx_tick = 4'(s_r.tx_tick + 4'h1);
          if (s_r.tx_tick == TICK_LAST) begin
            s_nxt.tx_st = TX_IDLE;
            s_nxt.txf = 1'b0;
            ev[IRQ_TX] = 1'b1;
          end
        end
        default: begin
          s_nxt.tx_st = TX_IDLE;
          s_nxt.tx_line = 1'b1;
        end
      endcase
    end

    // ********************************
    // Receiver
    // ********************************
    if (!run) begin
      s_nxt.rx_st = RX_IDLE;
    end else if (tick) begin
      case (s_r.rx_st)
        RX_IDLE: begin
          if (!s_r.rx_sync) begin
            s_nxt.rx_st = RX_START;
            s_nxt.rx_tick = '0;
          end
        end
        RX_START: begin
          s_nxt.rx_tick = 4'(s_r.rx_tick + 4'h1);
          // Recheck mid start bit; a short glitch is not a frame
          if (s_r.rx_tick == TICK_HALF) begin
            if (!s_r.rx_sync) begin
              s_nxt.rx_st = RX_DATA;
              s_nxt.rx_tick = '0;
              s_nxt.rx_bit = '0;
            end else begin
              s_nxt.rx_st = RX_IDLE;
            end
          end
        end
        RX_DATA: begin
          s_nxt.rx_tick = 4'(s_r.rx_tick + 4'h1);
          if (s_r.rx_tick == TICK_LAST) begin
            s_nxt.rx_sh = {s_r.rx_sync, s_r.rx_sh[7:1]};
            s_nxt.rx_bit = 3'(s_r.rx_bit + 3'h1);
            if (s_r.rx_bit == BIT_LAST) begin
              s_nxt.rx_st = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          s_nxt.rx_tick = 4'(s_r.rx_tick + 4'h1);
          if (s_r.rx_tick == TICK_LAST) begin
            s_nxt.rx_st = RX_IDLE;
            // Byte is kept even with a bad stop bit; the flag tells software
            s_nxt.rx_buf = s_r.rx_sh;
            s_nxt.rxf = 1'b1;
            ev[IRQ_RX] = 1'b1;
            // Overrun keeps the newer byte; the older one is lost
            ev[IRQ_OVR] = s_r.rxf && !rd_clear;
            ev[IRQ_FRM] = !s_r.rx_sync;
          end
        end
        default: begin
          s_nxt.rx_st = RX_IDLE;
        end
      endcase
    end

    // ********************************
    // Interrupts and pins
    // ********************************
    // New event beats a simultaneous clear
    s_nxt.ist = (s_r.ist & ~w1c) | ev;
    s_nxt.irq = |(s_nxt.ist & s_nxt.imsk);
    s_nxt.irq5 = uart_int_enable && s_nxt.rxf;
    // Level follows the flag, so an idle port keeps interrupt four raised
    s_nxt.irq4 = uart_int_enable && !s_nxt.txf;

    if (s_nxt.ctl[CTL_EN_BIT]) begin
      s_nxt.pad28.out = s_nxt.tx_line;
      s_nxt.pad28.oe = 1'b1;
      s_nxt.pad27.out = 1'b0;
      s_nxt.pad27.oe = 1'b0;
    end else begin
      s_nxt.pad28 = gio_drv_twenty_eight;
      s_nxt.pad27 = gio_drv_twenty_seven;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.ctl <= CTL_RESET;
      s_r.tx_st <= TX_IDLE;
      s_r.rx_st <= RX_IDLE;
      s_r.tx_line <= 1'b1;
      s_r.rx_meta <= 1'b1;
      s_r.rx_sync <= 1'b1;
      s_r.pad28 <= '{out: 1'b1, oe: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign general_io_pin_twenty_eight = s_r.pad28;
  assign general_io_pin_twenty_seven = s_r.pad27;
  assign cpu_irq_four = s_r.irq4;
  assign cpu_irq_five = s_r.irq5;
  assign irq = s_r.irq;

endmodule
`default_nettype wire

// >>> hw/usp_serial_port_files_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> bench/usp_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks
// ****
module usp_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire usp_pkg::usp_pad_t gio_drv_twenty_eight,
  input wire usp_pkg::usp_pad_t gio_drv_twenty_seven,
  input wire usp_pkg::usp_pad_t general_io_pin_twenty_eight,
  input wire usp_pkg::usp_pad_t general_io_pin_twenty_seven,
  input wire logic uart_int_enable,
  input wire logic cpu_irq_four,
  input wire logic cpu_irq_five
);
  import usp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rd_go, wr_go, on;
  assign rd_go = hsel && htrans[1] && hready && !hwrite;
  assign wr_go = hsel && htrans[1] && hready && hwrite;
  // Pin28 driven and pin27 input whenever the port runs
  assign on = general_io_pin_twenty_eight.oe && !general_io_pin_twenty_seven.oe;
  a_read_one_wait: assert property (rd_go |=> !hreadyout ##1 hreadyout) else $error("bad read wait");
  a_write_no_wait: assert property (wr_go |=> hreadyout) else $error("write stalled");
  a_read_clears_rx: assert property (rd_go && haddr == 32'h00030390 |-> ##3 !cpu_irq_five)
    else $error("receive full not cleared");
  a_five_gated: assert property (!uart_int_enable |=> !cpu_irq_five) else $error("irq five ungated");
  a_four_gated: assert property (!uart_int_enable |=> !cpu_irq_four) else $error("irq four ungated");
  a_write_sets_full: assert property (wr_go && haddr == 32'h00030390 && cpu_irq_four && on
    ##1 uart_int_enable [*3] |=> !cpu_irq_four) else $error("transmit full not set");
  a_full_holds: assert property ($fell(cpu_irq_four) && $past(uart_int_enable) && uart_int_enable
    ##1 uart_int_enable [*8] |-> !cpu_irq_four) else $error("transmit full cleared early");
  a_line_idle_high: assert property (uart_int_enable && cpu_irq_four && on
    |-> general_io_pin_twenty_eight.out) else $error("line not idle high");
  a_pin27_released: assert property (general_io_pin_twenty_seven.oe
    |-> general_io_pin_twenty_seven == $past(gio_drv_twenty_seven)) else $error("pin27 not released");
  a_pin28_released: assert property (!general_io_pin_twenty_eight.oe
    |-> general_io_pin_twenty_eight == $past(gio_drv_twenty_eight)) else $error("pin28 not released");
endmodule
bind usp_serial_port usp_properties u_usp_properties (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .gio_drv_twenty_eight, .gio_drv_twenty_seven, .general_io_pin_twenty_eight,
  .general_io_pin_twenty_seven, .uart_int_enable, .cpu_irq_four, .cpu_irq_five);
`default_nettype wire

// >>> bench/usp_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Remote serial device
// ****
module usp_remote_model (
  input wire logic clk,
  input wire logic tx_line,
  input var int bit_clk,
  output logic rx_line,
  output logic got,
  output logic [7:0] rx_byte
);
  logic [7:0] b;
  initial begin
    rx_line = 1'b1;
    got = 1'b0;
    rx_byte = 8'h00;
  end
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rx_line <= f[i];
      repeat (bit_clk - 1) @(posedge clk);
    end
  endtask
  // Mid-bit sampling tolerates a few percent of rate error
  always begin
    // Polled on the clock so zero-width pin glitches start no frame
    do @(posedge clk); while (tx_line !== 1'b0);
    repeat (bit_clk / 2) @(posedge clk);
    if (!tx_line) begin
      for (int i = 0; i < 8; i++) begin
        repeat (bit_clk) @(posedge clk);
        b[i] = tx_line;
      end
      repeat (bit_clk) @(posedge clk);
      got <= 1'b1;
      rx_byte <= b;
      @(posedge clk);
      got <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> bench/usp_serial_port_test.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Testbench
// ****
module usp_serial_port_test;
  import usp_pkg::*;
  localparam logic [31:0] CTL = 32'h00030380;
  localparam logic [31:0] STS = 32'h00030388;
  localparam logic [31:0] DAT = 32'h00030390;
  localparam logic [31:0] IST = 32'h00030400;
  localparam logic [31:0] IMK = 32'h00030408;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, rx_line, got, uie, irq4, irq5, irq, rd_ph;
  logic [31:0] haddr, hwdata, hrdata, seed;
  logic [1:0] htrans;
  logic [7:0] rx_byte, b;
  usp_pad_t g28, g27, p28, p27;
  int bit_clk, fails, checked;
  logic [31:0] rd_q[$];
  logic [7:0] tx_q[$];
  logic [15:0] ctl [3] = '{16'h0001, 16'h0003, 16'h0011};
  usp_serial_port u_usp_serial_port (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_pin(rx_line), .gio_drv_twenty_eight(g28),
    .gio_drv_twenty_seven(g27), .general_io_pin_twenty_eight(p28), .general_io_pin_twenty_seven(p27),
    .uart_int_enable(uie), .cpu_irq_four(irq4), .cpu_irq_five(irq5), .irq);
  // Released pin counts as idle so GPIO traffic is not decoded
  usp_remote_model u_usp_remote_model (.clk, .tx_line(p28.out | p27.oe), .bit_clk, .rx_line, .got, .rx_byte);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    if (!w) rd_q.push_back(d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask
  task automatic wt(input logic five);
    int n;
    n = 0;
    while ((five ? irq5 : irq4) !== 1'b1 && n < 60000) begin
      @(posedge clk);
      n++;
    end
    if (n == 60000) begin
      fails++;
      report_and_stop;
    end
  endtask
  task automatic report_and_stop;
    $display("Counts: %0d checked, %0d failed", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    if (rd_ph && hreadyout) cmp(hrdata, rd_q.pop_front());
    if (rd_ph && hreadyout) cmp({31'h0, hresp}, 32'h0);
    if (got) cmp({24'h0, rx_byte}, {24'h0, tx_q.pop_front()});
    if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
  end
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    report_and_stop;
  end
  initial begin
    seed = 32'h8680;
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    uie = 1'b1;
    g28 = 2'h0;
    g27 = 2'h1;
    rd_ph = 1'b0;
    bit_clk = 434;
    fails = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    bus(0, CTL, 32'h7);
    bus(0, STS, 32'h0);
    bus(0, 32'h00030384, 32'h0);
    bus(1, STS, 32'h3);
    bus(0, STS, 32'h0);
    for (int i = 0; i < 32; i++) begin
      bus(1, CTL, 32'(i));
      bus(0, CTL, 32'(i));
    end
    // Each ctl entry moves a byte at a different rate
    for (int k = 0; k < 3; k++) begin
      bus(1, CTL, {16'h0, ctl[k]});
      bit_clk = 50000000 / RATE_TABLE[ctl[k][3:1]] * (ctl[k][4] ? 8 : 1);
      b = 8'($random(seed));
      tx_q.push_back(b);
      wt(0);
      bus(1, DAT, {24'h0, b});
      bus(0, STS, 32'h1);
      wt(0);
      bus(0, STS, 32'h0);
    end
    bus(1, CTL, 32'h1);
    bit_clk = 434;
    bus(1, IST, 32'hf);
    b = 8'($random(seed));
    u_usp_remote_model.send(b);
    wt(1);
    cmp({31'h0, irq}, 32'h0);
    bus(0, IST, 32'h1);
    bus(1, IMK, 32'h1);
    repeat (2) @(posedge clk);
    cmp({31'h0, irq}, 32'h1);
    bus(1, IST, 32'h1);
    repeat (2) @(posedge clk);
    cmp({31'h0, irq}, 32'h0);
    // A second byte before the read overruns and replaces the first
    b = 8'($random(seed));
    u_usp_remote_model.send(b);
    bus(0, IST, 32'h5);
    bus(0, STS, 32'h2);
    bus(0, DAT, {24'h0, b});
    bus(0, STS, 32'h0);
    uie <= 1'b0;
    repeat (2) @(posedge clk);
    cmp({30'h0, irq4, irq5}, 32'h0);
    uie <= 1'b1;
    bus(1, CTL, 32'h0);
    g28 <= 2'($random(seed));
    g27 <= {1'($random(seed)), 1'b1};
    repeat (3) @(posedge clk);
    cmp({30'h0, p28}, {30'h0, g28});
    cmp({30'h0, p27}, {30'h0, g27});
    bus(1, CTL, 32'h1);
    repeat (2) @(posedge clk);
    cmp({28'h0, p28, p27}, 32'hc);
    report_and_stop;
  end
endmodule
`default_nettype wire
